// ---- pkg/qsi_pkg.sv ----
package qsi_pkg;

  // ----------------------------------------------------------------
  // Widths, depths, latencies
  // ----------------------------------------------------------------
  localparam int QSI_AW         = 18;  // Address bus width
  localparam int QSI_DW         = 18;  // Data word width
  localparam int QSI_FIFO_DEPTH = 8;   // Write-data buffer words
  localparam int QSI_RD_LAT     = 2;   // K cycles, read address to echo window
  localparam int QSI_K_HALF     = 4;   // System cycles per K half period

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int QSI_CLK_MHZ      = 100;
  localparam int QSI_GEN1_MAX_MHZ = 167;
  localparam int QSI_GEN2_MAX_MHZ = 200;
  // Least K half period in system cycles, rounded up
  localparam int QSI_MIN_HALF_G1  =
    (QSI_CLK_MHZ + 2 * QSI_GEN1_MAX_MHZ - 1) / (2 * QSI_GEN1_MAX_MHZ);
  localparam int QSI_MIN_HALF_G2  =
    (QSI_CLK_MHZ + 2 * QSI_GEN2_MAX_MHZ - 1) / (2 * QSI_GEN2_MAX_MHZ);

  // ----------------------------------------------------------------
  // Reset values of the pin drivers
  // ----------------------------------------------------------------
  localparam logic QSI_RST_K    = 1'b0;
  localparam logic QSI_RST_PS_N = 1'b1;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic {QSI_B2 = 1'b0, QSI_B4 = 1'b1} qsi_burst_t;
  typedef enum logic {QSI_SINGLE = 1'b0, QSI_MULTI = 1'b1} qsi_clk_mode_t;
  typedef enum logic {QSI_GEN1 = 1'b0, QSI_GEN2 = 1'b1} qsi_gen_t;

endpackage : qsi_pkg

// ---- pkg/qsi_fifo_if.sv ----
`timescale 1ns/1ns
interface qsi_fifo_if #(
  parameter int W     = qsi_pkg::QSI_DW,
  parameter int DEPTH = qsi_pkg::QSI_FIFO_DEPTH
);
  logic                         in_valid;
  logic                         in_ready;
  logic [W-1:0]                 in_data;
  logic                         out_valid;
  logic                         out_ready;
  logic [W-1:0]                 out_data;
  logic [$clog2(DEPTH+1)-1:0]   level;

  modport fifo (input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data, level);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data, level);
endinterface : qsi_fifo_if

// ---- src/qsi_fifo.sv ----
`timescale 1ns/1ns
module qsi_fifo #(
  parameter int W     = qsi_pkg::QSI_DW,         // Word width
  parameter int DEPTH = qsi_pkg::QSI_FIFO_DEPTH  // Word count
) (
  input wire logic clk_sys,  // System clock
  input wire logic arst_n,   // Async reset
  input wire logic ce,       // Clock enable
  qsi_fifo_if.fifo f         // Fill and drain sides
);
  import qsi_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("qsi_fifo: DEPTH must be a power of two");
  end

  logic [W-1:0]  mem_r [DEPTH];
  logic [W-1:0]  mem_nxt [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt;
  logic [PW-1:0] rp_r, rp_nxt;
  logic [LW-1:0] lvl_r, lvl_nxt;
  logic          rdy_r, rdy_nxt;
  logic          push;
  logic          pop;

  always_comb begin
    push    = f.in_valid & rdy_r;
    pop     = f.out_ready & (lvl_r != '0);
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    if (push) begin
      mem_nxt[wp_r] = f.in_data;
      wp_nxt        = wp_r + PW'(1);
    end
    if (pop) begin
      rp_nxt = rp_r + PW'(1);
    end
    lvl_nxt = lvl_r + LW'(push) - LW'(pop);
    rdy_nxt = (lvl_nxt != LW'(DEPTH));
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mem_r <= '{default: '0};
      wp_r  <= '0;
      rp_r  <= '0;
      lvl_r <= '0;
      rdy_r <= 1'b1;
    end else if (ce) begin
      mem_r <= mem_nxt;
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      lvl_r <= lvl_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  assign f.in_ready  = rdy_r;
  assign f.out_valid = (lvl_r != '0);
  assign f.out_data  = mem_r[rp_r];
  assign f.level     = lvl_r;

  full_stall_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (lvl_r == LW'(DEPTH)) |-> !rdy_r)
    else $error("fifo accepts while full");

endmodule : qsi_fifo

// ---- src/qsi_ctrl.sv ----
`timescale 1ns/1ns
// Operation
// - Separate one-way write and read data ports; no turnaround cycles
// - One address bus carries both read and write addresses
// - Data moves on both clock edges on write and read ports
// - Double-rate registers drive write data and K pair, capture read data; here single-edge clk_sys registers do all three
// - Single device: K pair times everything, C pair unused
// - Device bank: controller drives both K pair and C pair
// - Kn, Cn, CQn are always inverses of K, C, CQ
// - Controller drives C and K pairs; memory drives echo clocks back
// - Clock pairs come from output registers on neighbouring outputs
// - Read data captured with the edge-aligned echo clocks
// - Write data launched a quarter K period before each K edge
// - Read and write may be issued together with no idle cycle
// - Clock rate up to 167 MHz first, 200 MHz second generation
// - Burst-of-two and burst-of-four address sequencing supported
module qsi_ctrl
  import qsi_pkg::*;
#(
  parameter int            AW         = qsi_pkg::QSI_AW,         // Address width
  parameter int            DW         = qsi_pkg::QSI_DW,         // Data width
  parameter qsi_burst_t    BURST      = qsi_pkg::QSI_B2,         // Burst organisation
  parameter qsi_clk_mode_t CLK_MODE   = qsi_pkg::QSI_SINGLE,     // Clock mode
  parameter qsi_gen_t      GEN        = qsi_pkg::QSI_GEN2,       // Memory generation
  parameter int            K_HALF     = qsi_pkg::QSI_K_HALF,     // Cycles per K half
  parameter int            RD_LAT     = qsi_pkg::QSI_RD_LAT,     // Read latency, K cycles
  parameter int            FIFO_DEPTH = qsi_pkg::QSI_FIFO_DEPTH  // Write buffer words
) (
  input  wire logic          clk_sys,     // System clock
  input  wire logic          arst_n,      // Async reset
  input  wire logic          ce,          // Clock enable
  input  wire logic          cmd_valid,   // Command offered
  input  wire logic          cmd_rd,      // Command holds a read
  input  wire logic          cmd_wr,      // Command holds a write
  input  wire logic [AW-1:0] cmd_raddr,   // Read address
  input  wire logic [AW-1:0] cmd_waddr,   // Write address
  output logic               cmd_ready,   // Command taken this cycle
  input  wire logic          wr_valid,    // Write word offered
  input  wire logic [DW-1:0] wr_data,     // Write word
  output logic               wr_ready,    // Write buffer has room
  output logic               rd_valid,    // Read word pulse
  output logic [DW-1:0]      rd_data,     // Read word
  output logic               sram_k,      // Memory clock K
  output logic               sram_k_n,    // Memory clock Kn
  output logic               sram_c,      // Output clock C
  output logic               sram_c_n,    // Output clock Cn
  output logic [AW-1:0]      sram_sa,     // Shared address
  output logic               sram_rps_n,  // Read select
  output logic               sram_wps_n,  // Write select
  output logic [DW-1:0]      sram_d,      // Write data
  input  wire logic [DW-1:0] sram_q,      // Read data
  input  wire logic          sram_cq,     // Echo clock
  input  wire logic          sram_cq_n    // Echo clock, inverse
);
  import qsi_pkg::*;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // Phase plan
  // ----------------------------------------------------------------
  localparam int NB     = (BURST == QSI_B4) ? 4 : 2;
  localparam int Q      = K_HALF / 2;
  localparam int PH_LA  = 2 * K_HALF - Q;
  localparam int PH_LB  = K_HALF - Q;
  localparam int PH_ACC = PH_LA - 1;
  localparam int PW     = $clog2(2 * K_HALF);
  localparam int MINH   = (GEN == QSI_GEN1) ? QSI_MIN_HALF_G1 : QSI_MIN_HALF_G2;

  // Even half period keeps the quarter shift exact
  if (K_HALF < 4 || (K_HALF % 2) != 0 || K_HALF < MINH || RD_LAT < 2
      || FIFO_DEPTH < 2 * NB) begin : g_bad_param
    $error("qsi_ctrl: K_HALF, RD_LAT or FIFO_DEPTH out of range");
  end

  // ----------------------------------------------------------------
  // Write-data buffer
  // ----------------------------------------------------------------
  qsi_fifo_if #(.W(DW), .DEPTH(FIFO_DEPTH)) wf ();

  logic pop;

  qsi_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_wbuf (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .ce      (ce),
    .f       (wf.fifo)
  );

  assign wf.in_valid  = wr_valid;
  assign wf.in_data   = wr_data;
  assign wf.out_ready = pop;
  assign wr_ready     = wf.in_ready;

  // ----------------------------------------------------------------
  // Echo-domain synchronisers
  // ----------------------------------------------------------------
  logic [DW-1:0] q_s1_r, q_s2_r;
  logic          cq_s1_r, cq_s2_r, cq_s3_r;
  logic          cqn_s1_r, cqn_s2_r, cqn_s3_r;
  logic          echo_r, echo_nxt;

  // Only second and third stages feed the edge detector
  always_comb begin
    echo_nxt = (cq_s2_r & ~cq_s3_r) | (cqn_s2_r & ~cqn_s3_r);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q_s1_r   <= '0;
      q_s2_r   <= '0;
      cq_s1_r  <= 1'b0;
      cq_s2_r  <= 1'b0;
      cq_s3_r  <= 1'b0;
      // Inverse echo idles high while K is held low; avoids a false edge
      cqn_s1_r <= ~QSI_RST_K;
      cqn_s2_r <= ~QSI_RST_K;
      cqn_s3_r <= ~QSI_RST_K;
      echo_r   <= 1'b0;
    end else if (ce) begin
      q_s1_r   <= sram_q;
      q_s2_r   <= q_s1_r;
      cq_s1_r  <= sram_cq;
      cq_s2_r  <= cq_s1_r;
      cq_s3_r  <= cq_s2_r;
      cqn_s1_r <= sram_cq_n;
      cqn_s2_r <= cqn_s1_r;
      cqn_s3_r <= cqn_s2_r;
      echo_r   <= echo_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Clock, address and write-data drivers
  // ----------------------------------------------------------------
  logic [PW-1:0] ph_r, ph_nxt;
  logic          slot_r, slot_nxt;
  logic          k_r, k_nxt, k_n_r;
  logic          c_r, c_nxt, c_n_r;
  logic [AW-1:0] sa_r, sa_nxt;
  logic          rps_n_r, rps_nxt;
  logic          wps_n_r, wps_nxt;
  logic [AW-1:0] pw_addr_r, pw_addr_nxt;
  logic          pw_v_r, pw_v_nxt;
  logic [DW-1:0] d_r, d_nxt;
  logic [2:0]    left_r, left_nxt;
  logic          rdy_r, rdy_nxt;
  logic          k_wrap;
  logic          take;
  logic          lvl_ok;

  always_comb begin
    k_wrap   = (ph_r == PW'(2 * K_HALF - 1));
    take     = cmd_valid & rdy_r;
    // Reserve words still owed to an earlier burst
    lvl_ok   = int'(wf.level) >= NB + int'(left_r);
    ph_nxt   = k_wrap ? '0 : ph_r + PW'(1);
    slot_nxt = slot_r ^ (k_wrap && BURST == QSI_B4);
    k_nxt    = (ph_nxt < PW'(K_HALF));
    c_nxt    = (CLK_MODE == QSI_MULTI) && k_nxt;
    rdy_nxt  = (ph_nxt == PW'(PH_ACC)) && (BURST == QSI_B2 || slot_nxt)
               && (!cmd_wr || lvl_ok);
    sa_nxt      = sa_r;
    rps_nxt     = rps_n_r;
    wps_nxt     = wps_n_r;
    pw_addr_nxt = pw_addr_r;
    pw_v_nxt    = pw_v_r;
    d_nxt       = d_r;
    left_nxt    = left_r;
    pop         = 1'b0;
    if (ph_nxt == PW'(PH_LA)) begin
      rps_nxt = QSI_RST_PS_N;
      wps_nxt = QSI_RST_PS_N;
      if (take) begin
        rps_nxt     = ~cmd_rd;
        pw_addr_nxt = cmd_waddr;
        pw_v_nxt    = cmd_wr;
        if (cmd_rd) begin
          sa_nxt = cmd_raddr;
        end
        if (BURST == QSI_B2 && cmd_wr) begin
          left_nxt = 3'(NB);
        end
      end else if (BURST == QSI_B4 && pw_v_r) begin
        // Write address on the K rise after the read slot
        wps_nxt  = 1'b0;
        sa_nxt   = pw_addr_r;
        pw_v_nxt = 1'b0;
        left_nxt = 3'(NB);
      end
    end
    if (ph_nxt == PW'(PH_LB) && BURST == QSI_B2) begin
      rps_nxt = QSI_RST_PS_N;
      wps_nxt = ~pw_v_r;
      if (pw_v_r) begin
        sa_nxt   = pw_addr_r;
        pw_v_nxt = 1'b0;
      end
    end
    // Launch a quarter period ahead of each K or Kn rise
    if ((ph_nxt == PW'(PH_LA) || ph_nxt == PW'(PH_LB)) && left_nxt != '0) begin
      d_nxt    = wf.out_data;
      pop      = 1'b1;
      left_nxt = left_nxt - 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      // Last phase matches K low, so the first K high half is full length
      ph_r      <= PW'(2 * K_HALF - 1);
      slot_r    <= 1'b0;
      k_r       <= QSI_RST_K;
      k_n_r     <= ~QSI_RST_K;
      c_r       <= QSI_RST_K;
      c_n_r     <= ~QSI_RST_K;
      sa_r      <= '0;
      rps_n_r   <= QSI_RST_PS_N;
      wps_n_r   <= QSI_RST_PS_N;
      pw_addr_r <= '0;
      pw_v_r    <= 1'b0;
      d_r       <= '0;
      left_r    <= '0;
      rdy_r     <= 1'b0;
    end else if (ce) begin
      ph_r      <= ph_nxt;
      slot_r    <= slot_nxt;
      k_r       <= k_nxt;
      k_n_r     <= ~k_nxt;
      c_r       <= c_nxt;
      c_n_r     <= ~c_nxt;
      sa_r      <= sa_nxt;
      rps_n_r   <= rps_nxt;
      wps_n_r   <= wps_nxt;
      pw_addr_r <= pw_addr_nxt;
      pw_v_r    <= pw_v_nxt;
      d_r       <= d_nxt;
      left_r    <= left_nxt;
      rdy_r     <= rdy_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read tracking and capture
  // ----------------------------------------------------------------
  logic [RD_LAT-1:0] pipe_r, pipe_nxt;
  logic [3:0]        cap_r, cap_nxt;
  logic              rd_valid_r, rd_valid_nxt;
  logic [DW-1:0]     rd_data_r, rd_data_nxt;

  // Echo clocks run free; only edges inside a read window carry data
  always_comb begin
    pipe_nxt     = pipe_r;
    cap_nxt      = cap_r;
    rd_valid_nxt = 1'b0;
    rd_data_nxt  = rd_data_r;
    if (k_wrap) begin
      pipe_nxt = {pipe_r[RD_LAT-2:0], ~rps_n_r};
      if (pipe_r[RD_LAT-1]) begin
        cap_nxt = cap_nxt + 4'(NB);
      end
    end
    if (echo_r && cap_r != '0) begin
      rd_valid_nxt = 1'b1;
      rd_data_nxt  = q_s2_r;
      cap_nxt      = cap_nxt - 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pipe_r     <= '0;
      cap_r      <= '0;
      rd_valid_r <= 1'b0;
      rd_data_r  <= '0;
    end else if (ce) begin
      pipe_r     <= pipe_nxt;
      cap_r      <= cap_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r  <= rd_data_nxt;
    end
  end

  assign cmd_ready  = rdy_r;
  assign rd_valid   = rd_valid_r;
  assign rd_data    = rd_data_r;
  assign sram_k     = k_r;
  assign sram_k_n   = k_n_r;
  assign sram_c     = c_r;
  assign sram_c_n   = c_n_r;
  assign sram_sa    = sa_r;
  assign sram_rps_n = rps_n_r;
  assign sram_wps_n = wps_n_r;
  assign sram_d     = d_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence echo_s;
    ce && echo_r && cap_r != '0;
  endsequence

  sequence launch_s;
    $changed(d_r);
  endsequence

  clk_inverse_a: assert property (
    sram_k_n == !sram_k && sram_c_n == !sram_c)
    else $error("clock pair not complementary");
  k_phase_a: assert property (
    sram_k == (ph_r < PW'(K_HALF)))
    else $error("K level out of phase");
  c_mode_a: assert property (
    sram_c == ((CLK_MODE == QSI_MULTI) && sram_k))
    else $error("C clock wrong for mode");
  wdata_launch_a: assert property (
    launch_s |-> (ph_r == PW'(PH_LA) || ph_r == PW'(PH_LB)))
    else $error("write data launched off the quarter phase");
  rd_window_a: assert property (
    !sram_rps_n |-> (ph_r >= PW'(PH_LA) || ph_r < PW'(PH_LB)))
    else $error("read select not centred on K rise");
  wr_window_a: assert property (
    (BURST == QSI_B2 && !sram_wps_n) |-> (ph_r >= PW'(PH_LB) && ph_r < PW'(PH_LA)))
    else $error("write select not centred on Kn rise");
  b4_alternate_a: assert property (
    (BURST == QSI_B4) |-> (sram_rps_n || sram_wps_n))
    else $error("burst-of-four read and write share a K rise");
  ready_phase_a: assert property (
    cmd_ready |-> ph_r == PW'(PH_ACC))
    else $error("command taken off phase");
  wr_beats_a: assert property (
    (ce && cmd_valid && cmd_ready && cmd_wr && BURST == QSI_B2) |=> left_r == 3'(NB - 1))
    else $error("write burst length wrong");
  read_cap_a: assert property (
    echo_s |=> rd_valid && rd_data == $past(q_s2_r))
    else $error("echo edge did not deliver read word");

endmodule : qsi_ctrl

// ---- tb/qsi_sram_model.sv ----
`timescale 1ns/1ns
module qsi_sram_model #(
  parameter int LAT_HALF = 2 * qsi_pkg::QSI_RD_LAT,  // Half K periods, read address to beat
  parameter int TCO      = 3   // Clock to data and echo, ns
) (
  input  wire logic [qsi_pkg::QSI_AW-1:0] sram_sa,     // Shared address
  input  wire logic                       sram_k,      // Memory clock K
  input  wire logic                       sram_k_n,    // Memory clock Kn
  input  wire logic                       sram_rps_n,  // Read select
  input  wire logic                       sram_wps_n,  // Write select
  input  wire logic [qsi_pkg::QSI_DW-1:0] sram_d,      // Write data
  output logic      [qsi_pkg::QSI_DW-1:0] sram_q,      // Read data
  output logic                            sram_cq,     // Echo clock
  output logic                            sram_cq_n    // Echo clock, inverse
);
  import qsi_pkg::*;

  // ----------------------------------------------------------------
  // Storage and pending read beats
  // ----------------------------------------------------------------
  logic [QSI_DW-1:0] mem [logic [QSI_AW:0]];
  logic [QSI_DW-1:0] due [int];
  logic [QSI_DW-1:0] beat0;
  int                hc = 0;
  int                e;

  function automatic logic [QSI_DW-1:0] rd_word(input logic [QSI_AW:0] a);
    return mem.exists(a) ? mem[a] : '0;
  endfunction

  initial begin
    sram_q = '0;
  end

  // Echo clock mirrors K, so it runs free like the real part
  assign #TCO sram_cq = sram_k;
  assign sram_cq_n = ~sram_cq;

  // ----------------------------------------------------------------
  // Single-clock mode: K pair times both ports, C pair ignored
  // ----------------------------------------------------------------
  always @(posedge sram_k or posedge sram_k_n) begin
    e = hc;
    hc++;
    if (sram_k) begin
      beat0 = sram_d;
      if (sram_rps_n === 1'b0) begin
        due[e + LAT_HALF]     = rd_word({sram_sa, 1'b0});
        due[e + LAT_HALF + 1] = rd_word({sram_sa, 1'b1});
      end
    end else if (sram_wps_n === 1'b0) begin
      mem[{sram_sa, 1'b0}] = beat0;
      mem[{sram_sa, 1'b1}] = sram_d;
    end
    #TCO;
    // Idle data lines toggle so a stale word can never pass as fresh
    if (due.exists(e)) begin
      sram_q = due[e];
      due.delete(e);
    end else begin
      sram_q = ~sram_q;
    end
  end
endmodule  // qsi_sram_model

// ---- tb/quad_rate_sram_interface_test.sv ----
`timescale 1ns/1ns
module quad_rate_sram_interface_test;
  import qsi_pkg::*;

  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  logic              clk_sys   = 1'b0;
  logic              arst_n    = 1'b0;
  logic              ce        = 1'b1;
  bit                ce_rnd    = 1'b0;
  logic              cmd_valid = 1'b0;
  logic              cmd_rd    = 1'b0;
  logic              cmd_wr    = 1'b0;
  logic [QSI_AW-1:0] cmd_raddr = '0;
  logic [QSI_AW-1:0] cmd_waddr = '0;
  logic              wr_valid  = 1'b0;
  logic [QSI_DW-1:0] wr_data   = '0;
  logic              cmd_ready;
  logic              wr_ready;
  logic              rd_valid;
  logic [QSI_DW-1:0] rd_data;
  logic              sram_k;
  logic              sram_k_n;
  logic              sram_c;
  logic              sram_c_n;
  logic [QSI_AW-1:0] sram_sa;
  logic              sram_rps_n;
  logic              sram_wps_n;
  logic [QSI_DW-1:0] sram_d;
  logic [QSI_DW-1:0] sram_q;
  logic              sram_cq;
  logic              sram_cq_n;
  int                failures   = 0;
  int                n_compared = 0;
  int                cyc        = 0;
  logic [QSI_DW-1:0] exp_q [$];
  logic [QSI_DW-1:0] wq [$];
  logic [QSI_DW-1:0] ref_mem [logic [QSI_AW:0]];
  logic [QSI_AW-1:0] ra [4];
  logic [QSI_AW-1:0] wa [4];

  always #5 clk_sys = ~clk_sys;

  // Clock enable drops at random once reads are under way
  always @(posedge clk_sys) begin
    ce <= ce_rnd ? ($urandom_range(3) != 0) : 1'b1;
  end

  qsi_ctrl #(.BURST(QSI_B2), .CLK_MODE(QSI_SINGLE)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_rd(cmd_rd), .cmd_wr(cmd_wr), .cmd_raddr(cmd_raddr), .cmd_waddr(cmd_waddr),
    .cmd_ready(cmd_ready), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .sram_k(sram_k), .sram_k_n(sram_k_n),
    .sram_c(sram_c), .sram_c_n(sram_c_n), .sram_sa(sram_sa), .sram_rps_n(sram_rps_n),
    .sram_wps_n(sram_wps_n), .sram_d(sram_d), .sram_q(sram_q), .sram_cq(sram_cq),
    .sram_cq_n(sram_cq_n)
  );

  qsi_sram_model mem (
    .sram_sa(sram_sa), .sram_k(sram_k), .sram_k_n(sram_k_n), .sram_rps_n(sram_rps_n),
    .sram_wps_n(sram_wps_n), .sram_d(sram_d), .sram_q(sram_q), .sram_cq(sram_cq),
    .sram_cq_n(sram_cq_n)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input bit ok, input string what);
    n_compared++;
    if (!ok) begin
      failures++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  // Command stays offered with its fields until taken or the limit runs out
  task automatic send_cmd(input logic rd, input logic wr, input logic [QSI_AW-1:0] r,
                          input logic [QSI_AW-1:0] w, input int lim, output bit taken);
    int n;
    cmd_valid <= 1'b1;
    cmd_rd    <= rd;
    cmd_wr    <= wr;
    cmd_raddr <= r;
    cmd_waddr <= w;
    n = 0;
    taken = 1'b0;
    while (!taken && n < lim) begin
      @(posedge clk_sys);
      n++;
      taken = (cmd_ready === 1'b1 && ce === 1'b1);
    end
    // Read slot comes before the write slot of the same command
    if (taken && rd) begin
      exp_q.push_back(ref_mem[{r, 1'b0}]);
      exp_q.push_back(ref_mem[{r, 1'b1}]);
    end
    if (taken && wr) begin
      ref_mem[{w, 1'b0}] = wq.pop_front();
      ref_mem[{w, 1'b1}] = wq.pop_front();
    end
  endtask

  // Offers more words than fit; counts only real handshakes
  task automatic fill(output int got);
    got = 0;
    wr_valid <= 1'b1;
    wr_data  <= QSI_DW'($urandom);
    repeat (12) begin
      @(posedge clk_sys);
      if (wr_ready === 1'b1 && ce === 1'b1) begin
        wq.push_back(wr_data);
        got++;
        wr_data <= QSI_DW'($urandom);
      end
    end
    wr_valid <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Output watcher and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    cyc++;
    if (arst_n && (sram_k_n !== ~sram_k || sram_c !== 1'b0 || sram_c_n !== 1'b1)) begin
      check(1'b0, "clock pair wrong");
    end
    // A word stands while the enable is low; count it where the design moves on
    if (rd_valid === 1'b1 && ce === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(1'b0, "unexpected read word");
      end else begin
        check(rd_data === exp_q.pop_front(), "read word mismatch");
      end
    end
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    bit          tk;
    int          got;
    logic [31:0] tmp;
    void'($urandom(32'hbbb7f24b));
    for (int i = 0; i < 4; i++) begin
      tmp = $urandom;
      ra[i] = {tmp[QSI_AW-1:3], 3'(i)};
      wa[i] = {tmp[QSI_AW-1:3], 3'(i + 4)};
    end
    repeat (5) @(posedge clk_sys);
    tk = wr_ready === 1'b1 && sram_rps_n === 1'b1 && sram_wps_n === 1'b1;
    check(tk, "reset state");
    arst_n <= 1'b1;
    fill(got);
    check(got == QSI_FIFO_DEPTH, "buffer depth");
    for (int i = 0; i < 4; i++) begin
      send_cmd(1'b0, 1'b1, '0, wa[i], 100, tk);
      check(tk, "write command not taken");
    end
    // Buffer now drained: a write without its words must wait
    send_cmd(1'b0, 1'b1, '0, ra[0], 40, tk);
    check(!tk, "write taken without data");
    cmd_valid <= 1'b0;
    fill(got);
    check(got == QSI_FIFO_DEPTH, "buffer refill");
    for (int i = 0; i < 4; i++) begin
      send_cmd(1'b1, 1'b1, wa[i], ra[i], 100, tk);
      check(tk, "read and write command not taken");
    end
    ce_rnd = 1'b1;
    for (int i = 0; i < 4; i++) begin
      send_cmd(1'b1, 1'b0, ra[i], '0, 100, tk);
      check(tk, "read command not taken");
    end
    cmd_valid <= 1'b0;
    repeat (300) begin
      if (exp_q.size() != 0) begin
        @(posedge clk_sys);
      end
    end
    check(exp_q.size() == 0, "read words missing");
    stop_test();
  end
endmodule  // quad_rate_sram_interface_test
